// ===== rtl/bpw_power_wake.sv
// Wake handshake, sleep control and radio power-down for the baseband
`timescale 1ns/1ps
`default_nettype none

module bpw_power_wake
	import bpw_pkg::*;
#(
	parameter logic [DIV_W-1:0] LPO_DIV = bpw_pkg::LPO_DIV_CYCLES
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic uart_transport_sel,
	input wire logic wake_lines_en,
	input wire logic fold_flow_en,
	input wire logic wake_active_low,
	input wire logic attn_active_low,
	input wire logic wakeup_request_in,
	input wire logic cts_in,
	input wire logic uart_rts_flow,
	input wire logic sleep_criteria_met,
	input wire logic sw_sleep_cmd,
	input wire logic sw_wake_cmd,
	input wire logic lowpower_mode_enter,
	input wire logic [bpw_pkg::IVL_W-1:0] lowpower_interval,
	input wire logic host_event_raise,
	input wire logic host_event_delivered,
	input wire logic pkt_tx_active,
	input wire logic pkt_rx_active,
	input wire logic [bpw_pkg::RF_W-1:0] sw_radio_off,
	output logic host_wake_out,
	output logic rts_out,
	output logic cts_flow_out,
	output logic [bpw_pkg::RF_W-1:0] radio_pd,
	output logic lpo_select,
	output logic device_asleep
);
	import bpw_pkg::*;

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	bpw_state_e state_q;
	bpw_state_e state_d;
	logic attn_q;
	logic attn_d;
	logic [DIV_W-1:0] div_q;
	logic [DIV_W-1:0] div_d;
	logic [IVL_W-1:0] ivl_q;
	logic [IVL_W-1:0] ivl_d;
	logic host_wake_q;
	logic rts_q;
	logic cts_flow_q;
	logic [RF_W-1:0] pd_q;
	logic lpo_q;
	logic asleep_q;
	logic wake_pin_lvl;
	logic cts_pin_lvl;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	bpw_sync #(.RESET_VAL(1'b0)) u_sync_wake (
		.clock(clock),
		.reset(reset),
		.pin(wakeup_request_in),
		.level(wake_pin_lvl)
	);

	bpw_sync #(.RESET_VAL(1'b0)) u_sync_cts (
		.clock(clock),
		.reset(reset),
		.pin(cts_in),
		.level(cts_pin_lvl)
	);

	// ----------------------------------------
	// Line selection and wake decode
	// ----------------------------------------
	wire dedicated = uart_transport_sel & wake_lines_en;
	wire folded = uart_transport_sel & fold_flow_en & ~wake_lines_en;
	wire saving_q = (state_q != BPW_ACTIVE);
	wire wake_ded = dedicated & (wake_pin_lvl ^ wake_active_low);
	wire wake_fold = folded & saving_q & (cts_pin_lvl ^ wake_active_low);
	wire wake_req = wake_ded | wake_fold;
	wire sleep_ok = ~wake_req & ~sw_wake_cmd & sleep_criteria_met;
	wire go_lowpwr = sleep_ok & lowpower_mode_enter;
	wire go_sleep = sleep_ok & sw_sleep_cmd;

	// Low-power clock enable and interval expiry
	wire lpo_tick = saving_q & (div_q == LPO_DIV - DIV_ONE);
	wire ivl_done = lpo_tick & (ivl_q <= IVL_ONE);

	// ----------------------------------------
	// Power state machine
	// ----------------------------------------
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			BPW_ACTIVE: begin
				if (go_lowpwr) begin
					state_d = BPW_LOWPWR;
				end else if (go_sleep) begin
					state_d = BPW_SLEEP;
				end
			end
			BPW_SLEEP: begin
				if (wake_req | sw_wake_cmd) begin
					state_d = BPW_ACTIVE;
				end
			end
			BPW_LOWPWR: begin
				if (wake_req | sw_wake_cmd | ivl_done) begin
					state_d = BPW_ACTIVE;
				end
			end
			default: begin
				state_d = BPW_ACTIVE;
			end
		endcase
	end

	// Divider runs only while on the low-power clock
	assign div_d = (~saving_q | lpo_tick) ? DIV_ZERO : div_q + DIV_ONE;

	// Interval loads on entry and counts low-power ticks
	assign ivl_d = (state_q == BPW_ACTIVE && go_lowpwr) ? lowpower_interval :
		(lpo_tick && ivl_q != '0) ? ivl_q - IVL_ONE : ivl_q;

	// Attention holds until delivered; a new event wins over delivery
	assign attn_d = host_event_raise | (attn_q & ~host_event_delivered);

	// ----------------------------------------
	// Output decode from next state
	// ----------------------------------------
	wire awake_d = (state_d == BPW_ACTIVE);
	wire tx_on = awake_d & pkt_tx_active & ~sw_radio_off[RF_TX];
	wire rx_on = awake_d & pkt_rx_active & ~sw_radio_off[RF_RX];
	wire pa_on = tx_on & ~sw_radio_off[RF_PA];
	wire pll_on = (tx_on | rx_on) & ~sw_radio_off[RF_PLL];
	wire [RF_W-1:0] pd_d = {~pa_on, ~pll_on, ~rx_on, ~tx_on};
	wire attn_lvl = attn_d ^ attn_active_low;
	wire idle_lvl = attn_active_low;
	wire host_wake_d = dedicated ? attn_lvl : idle_lvl;
	wire rts_d = (folded & ~awake_d) ? attn_lvl : uart_rts_flow;
	wire cts_flow_d = folded ? (awake_d & cts_pin_lvl) : cts_pin_lvl;

	// ----------------------------------------
	// State registers
	// ----------------------------------------
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			state_q <= BPW_ACTIVE;
			attn_q <= 1'b0;
			div_q <= DIV_ZERO;
			ivl_q <= '0;
		end else begin
			state_q <= state_d;
			attn_q <= attn_d;
			div_q <= div_d;
			ivl_q <= ivl_d;
		end
	end

	// Output registers
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			host_wake_q <= 1'b0;
			rts_q <= 1'b0;
			cts_flow_q <= 1'b0;
			pd_q <= RF_ALL_DOWN;
			lpo_q <= 1'b0;
			asleep_q <= 1'b0;
		end else begin
			host_wake_q <= host_wake_d;
			rts_q <= rts_d;
			cts_flow_q <= cts_flow_d;
			pd_q <= pd_d;
			lpo_q <= ~awake_d;
			asleep_q <= ~awake_d;
		end
	end

	assign host_wake_out = host_wake_q;
	assign rts_out = rts_q;
	assign cts_flow_out = cts_flow_q;
	assign radio_pd = pd_q;
	assign lpo_select = lpo_q;
	assign device_asleep = asleep_q;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	sequence seq_wake_seen;
		wake_req && !reset;
	endsequence

	sequence seq_fall_asleep;
		(state_q == BPW_ACTIVE) ##1 (state_q != BPW_ACTIVE);
	endsequence

	sequence seq_lowpwr_expire;
		(state_q == BPW_LOWPWR) && ivl_done;
	endsequence

	chk_wake_keeps_awake: assert property (seq_wake_seen |=> state_q == BPW_ACTIVE)
		else $error("wake request did not keep device awake");

	chk_sleep_needs_criteria: assert property (seq_fall_asleep |->
		$past(sleep_criteria_met) && !$past(wake_req))
		else $error("sleep entered without criteria");

	chk_attn_holds: assert property (attn_q && !host_event_delivered |=> attn_q)
		else $error("attention dropped before delivery");

	chk_attn_release: assert property (attn_q && host_event_delivered && !host_event_raise
		|=> !attn_q)
		else $error("attention not released after delivery");

	chk_attn_polarity: assert property ($past(dedicated) && $stable(attn_active_low)
		|-> host_wake_out == (attn_q ^ attn_active_low))
		else $error("attention output level wrong");

	chk_lines_unused: assert property (!$past(dedicated) && $stable(attn_active_low)
		|-> host_wake_out == attn_active_low)
		else $error("attention line driven while unused");

	chk_rts_folded: assert property ($past(folded) && $stable(attn_active_low)
		&& saving_q && attn_q |-> rts_out == !attn_active_low)
		else $error("folded attention not shown on flow line");

	chk_radio_down_asleep: assert property (saving_q |-> radio_pd == RF_ALL_DOWN
		&& lpo_select)
		else $error("radio powered while asleep");

	chk_radio_in_packet: assert property (awake_d && pkt_tx_active && pkt_rx_active
		&& sw_radio_off == RF_NONE |=> radio_pd == RF_NONE)
		else $error("radio not powered during packet");

	// Wake edge itself leaves the low-power clock; a fresh entry may follow at once
	chk_interval_wake: assert property (seq_lowpwr_expire |=> state_q == BPW_ACTIVE
		&& !lpo_select)
		else $error("no wake at interval expiry");

	chk_sw_wake: assert property (saving_q && sw_wake_cmd |=> state_q == BPW_ACTIVE)
		else $error("software wake ignored");
endmodule

`default_nettype wire

// ===== rtl/bpw_pkg.sv
// Shared constants and the pin synchroniser of the wake handshake block
`timescale 1ns/1ps
`default_nettype none

package bpw_pkg;
	// ----------------------------------------
	// Clock rates and divider
	// ----------------------------------------
	localparam int unsigned CLK_HZ = 125_000_000;
	localparam int unsigned LPO_HZ = 32_768;
	localparam int unsigned LPO_DIV_INT = CLK_HZ / LPO_HZ;
	localparam int DIV_W = 12;
	localparam logic [DIV_W-1:0] LPO_DIV_CYCLES = DIV_W'(LPO_DIV_INT);
	localparam logic [DIV_W-1:0] DIV_ZERO = 12'h000;
	localparam logic [DIV_W-1:0] DIV_ONE = 12'h001;

	// ----------------------------------------
	// Radio power-down vector layout
	// ----------------------------------------
	localparam int RF_W = 4;
	localparam int RF_TX = 0;
	localparam int RF_RX = 1;
	localparam int RF_PLL = 2;
	localparam int RF_PA = 3;
	localparam logic [RF_W-1:0] RF_ALL_DOWN = 4'hF;
	localparam logic [RF_W-1:0] RF_NONE = 4'h0;

	// ----------------------------------------
	// Sleep interval counter
	// ----------------------------------------
	localparam int IVL_W = 16;
	localparam logic [IVL_W-1:0] IVL_ONE = 16'h0001;

	// ----------------------------------------
	// Power states
	// ----------------------------------------
	typedef enum logic [1:0] {
		BPW_ACTIVE = 2'b00,
		BPW_SLEEP = 2'b01,
		BPW_LOWPWR = 2'b10
	} bpw_state_e;
endpackage

// ----------------------------------------
// Three-stage synchroniser with agreement filter
// ----------------------------------------
module bpw_sync #(
	parameter logic RESET_VAL = 1'b0
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic pin,
	output logic level
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic level_q;

	// Shift chain; the first stage feeds only the second
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			s1_q <= RESET_VAL;
			s2_q <= RESET_VAL;
			s3_q <= RESET_VAL;
		end else begin
			s1_q <= pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Accept a change once stages two and three agree
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			level_q <= RESET_VAL;
		end else if (s2_q == s3_q) begin
			level_q <= s3_q;
		end
	end

	assign level = level_q;
endmodule

`default_nettype wire

// ===== verification/bpw_host_model.sv
// Host-side model that answers the wake handshake of the power control block
`timescale 1ns/1ps
`default_nettype none

module bpw_host_model (
	input wire logic clock,
	input wire logic reset,
	input wire logic wake_active_low,
	input wire logic attn_active_low,
	input wire logic want_wake,
	input wire logic want_cts,
	input wire logic host_wake_out,
	output logic wakeup_request_in,
	output logic cts_in,
	output logic host_awake
);
	// ----------------------------------------
	// Pins and host power state
	// ----------------------------------------
	logic attn_seen;

	// Attention decoded with the selected polarity
	assign attn_seen = host_wake_out ^ attn_active_low;

	// Pins change only just after a rising edge, at the chosen polarity
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			wakeup_request_in <= wake_active_low;
			cts_in <= wake_active_low;
			host_awake <= 1'h1;
		end else begin
			wakeup_request_in <= want_wake ^ wake_active_low;
			cts_in <= want_cts ^ wake_active_low;
			host_awake <= attn_seen | want_wake;
		end
	end
endmodule

`default_nettype wire

// ===== verification/testbench.sv
// Self-checking bench for the wake handshake and radio power control
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import bpw_pkg::*;
	logic clock, reset, uart_transport_sel, wake_lines_en, fold_flow_en;
	logic wake_active_low, attn_active_low, wakeup_request_in, cts_in, uart_rts_flow;
	logic sleep_criteria_met, sw_sleep_cmd, sw_wake_cmd, lowpower_mode_enter;
	logic host_event_raise, host_event_delivered, pkt_tx_active, pkt_rx_active;
	logic want_wake, want_cts, host_awake;
	logic host_wake_out, rts_out, cts_flow_out, lpo_select, device_asleep;
	logic [IVL_W-1:0] lowpower_interval;
	logic [RF_W-1:0] sw_radio_off, radio_pd;
	int n_errors, check_count;

	// Short low-power tick keeps the interval waits brief
	bpw_power_wake #(.LPO_DIV(12'h008)) i_bpw_power_wake (.clock, .reset,
		.uart_transport_sel, .wake_lines_en, .fold_flow_en, .wake_active_low,
		.attn_active_low, .wakeup_request_in, .cts_in, .uart_rts_flow,
		.sleep_criteria_met, .sw_sleep_cmd, .sw_wake_cmd, .lowpower_mode_enter,
		.lowpower_interval, .host_event_raise, .host_event_delivered, .pkt_tx_active,
		.pkt_rx_active, .sw_radio_off, .host_wake_out, .rts_out, .cts_flow_out,
		.radio_pd, .lpo_select, .device_asleep);
	bpw_host_model i_bpw_host_model (.clock, .reset, .wake_active_low,
		.attn_active_low, .want_wake, .want_cts, .host_wake_out,
		.wakeup_request_in, .cts_in, .host_awake);

	// ----------------------------------------
	// Clock, helpers and closing
	// ----------------------------------------
	initial begin
		clock = 1'h0;
		forever #4 clock = ~clock;
	end

	task automatic chk(input logic [3:0] got, input logic [3:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clock);
	endtask

	// Bounded wait for the sleep flag to reach a level
	task automatic wait_sleep(input logic v);
		for (int i = 0; i < 30 && device_asleep !== v; i++) cyc(1);
	endtask

	task automatic go_sleep();
		sleep_criteria_met = 1'h1;
		sw_sleep_cmd = 1'h1;
		cyc(1);
		sw_sleep_cmd = 1'h0;
		chk(device_asleep, 1'h1);
		chk(radio_pd, RF_ALL_DOWN);
	endtask

	task automatic rf(input logic tx, input logic rx, input logic [3:0] off, input logic [3:0] exp);
		pkt_tx_active = tx;
		pkt_rx_active = rx;
		sw_radio_off = off;
		cyc(1);
		chk(radio_pd, exp);
	endtask

	task automatic finish_test();
		$display("Checks %0d, errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	// Sleep needs criteria, wake request ends it and blocks it, per polarity
	task automatic t_sleep_wake(input logic pol);
		wake_active_low = pol;
		sleep_criteria_met = 1'h0;
		sw_sleep_cmd = 1'h1;
		cyc(8);
		sw_sleep_cmd = 1'h0;
		chk(device_asleep, 1'h0);
		go_sleep();
		chk(lpo_select, 1'h1);
		want_wake = 1'h1;
		wait_sleep(1'h0);
		chk(device_asleep, 1'h0);
		sw_sleep_cmd = 1'h1;
		cyc(3);
		chk(device_asleep, 1'h0);
		sw_sleep_cmd = 1'h0;
		want_wake = 1'h0;
		cyc(6);
	endtask

	// Low-power mode wakes by itself after two ticks
	task automatic t_interval();
		lowpower_interval = 16'h0002;
		lowpower_mode_enter = 1'h1;
		cyc(1);
		lowpower_mode_enter = 1'h0;
		chk(device_asleep, 1'h1);
		cyc(10);
		chk(lpo_select, 1'h1);
		wait_sleep(1'h0);
		chk(lpo_select, 1'h0);
	endtask

	// Attention holds until delivery, for both polarities
	task automatic t_attn(input logic pol);
		attn_active_low = pol;
		cyc(2);
		host_event_raise = 1'h1;
		cyc(1);
		host_event_raise = 1'h0;
		chk(host_wake_out, !pol);
		cyc(4);
		chk(host_wake_out, !pol);
		chk(host_awake, 1'h1);
		host_event_delivered = 1'h1;
		cyc(1);
		host_event_delivered = 1'h0;
		chk(host_wake_out, pol);
	endtask

	// Wake line ignored unless UART transport and enabled; software command still wakes
	task automatic t_gate(input logic uart, input logic en);
		uart_transport_sel = uart;
		wake_lines_en = en;
		go_sleep();
		want_wake = 1'h1;
		cyc(10);
		chk(device_asleep, 1'h1);
		chk(host_wake_out, attn_active_low);
		sw_wake_cmd = 1'h1;
		wait_sleep(1'h0);
		sw_wake_cmd = 1'h0;
		chk(device_asleep, 1'h0);
		want_wake = 1'h0;
		cyc(6);
	endtask

	// Folded lines: flow control awake, wake and attention when asleep
	task automatic t_fold();
		fold_flow_en = 1'h1;
		uart_rts_flow = 1'h1;
		cyc(1);
		chk(rts_out, 1'h1);
		uart_rts_flow = 1'h0;
		cyc(1);
		chk(rts_out, 1'h0);
		go_sleep();
		host_event_raise = 1'h1;
		cyc(1);
		host_event_raise = 1'h0;
		cyc(1);
		chk(rts_out, !attn_active_low);
		want_cts = 1'h1;
		wait_sleep(1'h0);
		cyc(1);
		chk(cts_flow_out, 1'h1);
		want_cts = 1'h0;
		host_event_delivered = 1'h1;
		cyc(1);
		host_event_delivered = 1'h0;
	endtask

	// Main sequence with reset held for twelve cycles
	initial begin
		reset = 1'h1;
		uart_transport_sel = 1'h1;
		wake_lines_en = 1'h1;
		{fold_flow_en, wake_active_low, attn_active_low, uart_rts_flow, want_wake} = '0;
		{sleep_criteria_met, sw_sleep_cmd, sw_wake_cmd, lowpower_mode_enter, want_cts} = '0;
		{host_event_raise, host_event_delivered, pkt_tx_active, pkt_rx_active} = '0;
		lowpower_interval = 16'h0000;
		sw_radio_off = 4'h0;
		n_errors = 0;
		check_count = 0;
		cyc(12);
		reset = 1'h0;
		cyc(6);
		chk(radio_pd, RF_ALL_DOWN);
		chk(device_asleep, 1'h0);
		t_sleep_wake(1'h0);
		t_sleep_wake(1'h1);
		wake_active_low = 1'h0;
		cyc(6);
		t_interval();
		t_attn(1'h0);
		t_attn(1'h1);
		rf(1'h1, 1'h0, 4'h0, 4'h2);
		rf(1'h0, 1'h1, 4'h0, 4'h9);
		rf(1'h1, 1'h1, 4'h0, 4'h0);
		rf(1'h1, 1'h0, 4'h8, 4'hA);
		rf(1'h0, 1'h0, 4'h0, 4'hF);
		t_gate(1'h0, 1'h1);
		t_gate(1'h1, 1'h0);
		t_fold();
		finish_test();
	end

	// Watchdog well beyond the expected run length
	initial begin
		repeat (3000) @(posedge clock);
		n_errors++;
		finish_test();
	end
endmodule

`default_nettype wire
